//--- digitizer_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DIGITIZER_DEFS_SVH
`define DIGITIZER_DEFS_SVH

`define REG_CTRL          8'h00
`define REG_DIVISOR       8'h04
`define REG_PHASE_MULT    8'h08
`define REG_HIRES_RATE    8'h0C
`define REG_STATUS        8'h10
`define REG_RESULT_INFO   8'h14

`define CTRL_HIRES_BIT    0
`define CTRL_PHASE_BIT    1
`define CTRL_CAL_BIT      4
`define CTRL_RESTORE_BIT  5

`define STAT_OVERLOAD_BIT 0
`define STAT_TEMP_BIT     1
`define STAT_CAL_BUSY_BIT 2
`define STAT_CAL_FAIL_BIT 3

`define DIVISOR_RESET     32'h0000_0000
`define PHASE_MULT_MIN    4'h2
`define PHASE_MULT_MAX    4'hA
`define HIRES_RATE_RESET  4'h0
`define HIRES_RATE_LAST   4'h9

`define BASE_RATE_MSPS    100
`define SAMPLE_BITS       8
`define RESULT_BITS       21
`define ACC_BITS          22
`define TEMP_LIMIT_C      8'sd5
`define RANGE_LAST        3'h6

`define CLOCK_MHZ         10
`define SETTLE_TIME_US    1000
`define SETTLE_CYCLES     (`SETTLE_TIME_US * `CLOCK_MHZ)

`endif

//--- digitizer_pkg.sv
// types shared by the digitizer mode and rate control
`default_nettype none
package digitizer_pkg;

  typedef enum logic [2:0] {
    CAL_IDLE     = 3'b000,
    CAL_RECENTER = 3'b001,
    CAL_SETTLE   = 3'b010,
    CAL_GAIN     = 3'b011,
    CAL_LINEAR   = 3'b100,
    CAL_TIMING   = 3'b101
  } cal_state_t;

  typedef enum logic [1:0] {
    OP_GAIN_OFFSET = 2'b00,
    OP_LINEARITY   = 2'b01,
    OP_TIMING      = 2'b10
  } cal_op_t;

endpackage : digitizer_pkg
`default_nettype wire

//--- hires_filter.sv
// lowpass and resampler for the high-resolution acquisition mode
`include "digitizer_defs.svh"
`default_nettype none
module hires_filter
  import digitizer_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     enable,
  input  wire logic [`SAMPLE_BITS-1:0]  sample,
  input  wire logic [3:0]               rate_sel,
  output logic                          out_valid,
  output logic [`RESULT_BITS-1:0]       out_data
);

  // samples summed per output word at each selectable rate
  function automatic logic [13:0] ratio_of(input logic [3:0] sel);
    unique case (sel)
      4'h0: ratio_of = 14'd8;
      4'h1: ratio_of = 14'd20;
      4'h2: ratio_of = 14'd40;
      4'h3: ratio_of = 14'd100;
      4'h4: ratio_of = 14'd200;
      4'h5: ratio_of = 14'd500;
      4'h6: ratio_of = 14'd1000;
      4'h7: ratio_of = 14'd2000;
      4'h8: ratio_of = 14'd5000;
      default: ratio_of = 14'd10000;
    endcase
  endfunction : ratio_of

  // whole result bits kept at each rate, low bits are noise
  function automatic logic [4:0] bits_of(input logic [3:0] sel);
    unique case (sel)
      4'h0: bits_of = 5'd11;
      4'h1: bits_of = 5'd14;
      4'h2: bits_of = 5'd15;
      4'h3: bits_of = 5'd17;
      4'h4: bits_of = 5'd18;
      4'h5: bits_of = 5'd18;
      4'h6: bits_of = 5'd19;
      4'h7: bits_of = 5'd19;
      4'h8: bits_of = 5'd20;
      default: bits_of = 5'd21;
    endcase
  endfunction : bits_of

  logic [`ACC_BITS-1:0]    acc_q;
  logic [13:0]             count_q;
  logic [`RESULT_BITS-1:0] mask;

  assign mask = ~(`RESULT_BITS'h1FFFFF >> bits_of(rate_sel));

  // boxcar accumulate, dump one wide word per ratio samples
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q     <= '0;
      count_q   <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (!enable) begin
      acc_q     <= '0;
      count_q   <= '0;
      out_valid <= 1'b0;
    end else if (count_q == ratio_of(rate_sel) - 14'd1) begin
      acc_q     <= '0;
      count_q   <= '0;
      out_valid <= 1'b1;
      out_data  <= (acc_q[`ACC_BITS-1:1] + `RESULT_BITS'(sample >> 1))
                   & mask;
    end else begin
      acc_q     <= acc_q + `ACC_BITS'(sample);
      count_q   <= count_q + 14'd1;
      out_valid <= 1'b0;
    end
  end

endmodule : hires_filter
`default_nettype wire

//--- digitizer_ctrl.sv
// acquisition mode, rate, error and calibration control behind axi4-lite
`include "digitizer_defs.svh"
`default_nettype none
// Behaviour
// RULE_01: direct mode stores eight-bit samples, 100 MS/s base
// RULE_02: converter runs always; only a fraction stored
// RULE_03: direct rate is base divided by n
// RULE_04: phase sampling multiplies rate by 2 to 10
// RULE_05: phase sampling, repetitive signals only, max 1 GS/s
// RULE_06: fastest high-resolution rate gives 11-bit results
// RULE_07: slowest high-resolution rate gives 21-bit results
// RULE_08: high resolution filters then resamples to wider words
// RULE_09: converter overrange in high resolution raises error
// RULE_10: software then picks larger range or attenuates
// RULE_11: temperature beyond 5 degrees raises warning
// RULE_12: software command starts internal calibration
// RULE_13: recentre heater, settle, gain, linearity, timing steps
// RULE_14: restore reloads factory settings after failed calibration
// RULE_15: error flags stay set until software clears
module digitizer_ctrl
  import digitizer_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic [`SAMPLE_BITS-1:0] adc_data,
  input  wire logic                    adc_overrange,
  input  wire logic [7:0]              temp_offset_c,
  input  wire logic                    heater_stable,
  input  wire logic                    cal_step_done,
  input  wire logic                    cal_step_fail,
  input  wire logic                    repeat_start,
  output logic                         store_valid,
  output logic [`RESULT_BITS-1:0]      store_data,
  output logic [3:0]                   store_phase,
  output logic                         heater_recenter,
  output logic                         cal_step_go,
  output logic [1:0]                   cal_op,
  output logic [2:0]                   cal_range,
  output logic                         restore_factory
);

  // pin synchronisers: first stage is read only by the second
  logic [`SAMPLE_BITS-1:0] adc_s1_q, adc_s2_q;
  logic [7:0]              temp_s1_q, temp_s2_q;
  logic [4:0]              pin_s1_q, pin_s2_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      adc_s1_q  <= '0;
      adc_s2_q  <= '0;
      temp_s1_q <= '0;
      temp_s2_q <= '0;
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
    end else begin
      adc_s1_q  <= adc_data;
      adc_s2_q  <= adc_s1_q;
      temp_s1_q <= temp_offset_c;
      temp_s2_q <= temp_s1_q;
      pin_s1_q  <= {repeat_start, cal_step_fail, cal_step_done,
                    heater_stable, adc_overrange};
      pin_s2_q  <= pin_s1_q;
    end
  end
  logic overrange, stable, step_done, step_fail, rep_start;
  assign {rep_start, step_fail, step_done, stable, overrange} =
    pin_s2_q;

  // control registers written by software
  logic        hires_q, phase_q;
  logic [31:0] divisor_q;                // holds n minus one
  logic [3:0]  mult_q, rate_q;
  logic        overload_q, temp_warn_q, cal_fail_q;
  cal_state_t  cal_q;
  logic        wr_fire, aw_held_q, w_held_q;
  logic [7:0]  waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // write channel: address and data taken in either order
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      waddr_q       <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_q       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waddr_q[7:2] <= `REG_RESULT_INFO >> 2)
                        ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                       input logic [31:0] nw,
                                       input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  logic wr_ctrl, wr_status, cal_cmd, restore_cmd, cal_idle;
  logic [31:0] ctrl_new;
  assign wr_ctrl   = wr_fire && waddr_q == `REG_CTRL;
  assign wr_status = wr_fire && waddr_q == `REG_STATUS && wstrb_q[0];
  assign ctrl_new  = merge({30'h0, phase_q, hires_q}, wdata_q, wstrb_q);
  assign cal_idle  = cal_q == CAL_IDLE;
  assign cal_cmd   = wr_ctrl && wstrb_q[0] && wdata_q[`CTRL_CAL_BIT];
  assign restore_cmd = wr_ctrl && wstrb_q[0] &&
                       wdata_q[`CTRL_RESTORE_BIT] && cal_idle;

  // mode, divisor, multiplier and rate selection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hires_q   <= 1'b0;
      phase_q   <= 1'b0;
      divisor_q <= `DIVISOR_RESET;
      mult_q    <= `PHASE_MULT_MIN;
      rate_q    <= `HIRES_RATE_RESET;
    end else if (wr_fire) begin
      if (waddr_q == `REG_CTRL) begin
        hires_q <= ctrl_new[`CTRL_HIRES_BIT];
        phase_q <= ctrl_new[`CTRL_PHASE_BIT];
      end
      if (waddr_q == `REG_DIVISOR) begin
        divisor_q <= merge(divisor_q, wdata_q, wstrb_q);   // RULE_03
      end
      // clamp keeps the multiplier in 2..10, so never above 1 GS/s
      if (waddr_q == `REG_PHASE_MULT && wstrb_q[0]) begin
        mult_q <= (wdata_q[3:0] < `PHASE_MULT_MIN) ? `PHASE_MULT_MIN :
                  (wdata_q[3:0] > `PHASE_MULT_MAX) ? `PHASE_MULT_MAX :
                  wdata_q[3:0];                               // RULE_04
      end
      if (waddr_q == `REG_HIRES_RATE && wstrb_q[0]) begin
        rate_q <= (wdata_q[3:0] > `HIRES_RATE_LAST) ? `HIRES_RATE_LAST
                  : wdata_q[3:0];                      // RULE_06 RULE_07
      end
    end
  end

  // sticky error flags; a new event wins over a clear
  logic temp_out;
  assign temp_out = ($signed(temp_s2_q) > `TEMP_LIMIT_C) ||
                    ($signed(temp_s2_q) < -`TEMP_LIMIT_C);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overload_q  <= 1'b0;
      temp_warn_q <= 1'b0;
    end else begin
      if (hires_q && overrange) begin
        overload_q <= 1'b1;                                // RULE_09
      end else if (wr_status && wdata_q[`STAT_OVERLOAD_BIT]) begin
        overload_q <= 1'b0;                                // RULE_15
      end
      if (temp_out) begin
        temp_warn_q <= 1'b1;                               // RULE_11
      end else if (wr_status && wdata_q[`STAT_TEMP_BIT]) begin
        temp_warn_q <= 1'b0;                               // RULE_15
      end
    end
  end

  // direct mode: converter never stops, decimator picks one in n
  logic [31:0] dec_cnt_q;
  logic        dec_hit;
  assign dec_hit = dec_cnt_q >= divisor_q;  // no stall if n shrinks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt_q <= '0;
    end else if (hires_q || phase_q || dec_hit) begin
      dec_cnt_q <= '0;                                     // RULE_02
    end else begin
      dec_cnt_q <= dec_cnt_q + 32'd1;                      // RULE_03
    end
  end

  // phase slot advances per repetition of the repetitive waveform
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      store_phase <= '0;
    end else if (!phase_q || hires_q) begin
      store_phase <= '0;
    end else if (rep_start || store_phase >= mult_q) begin
      store_phase <= (store_phase >= mult_q - 4'd1) ? 4'd0
                     : store_phase + 4'd1;                 // RULE_05
    end
  end

  logic                    hr_valid;
  logic [`RESULT_BITS-1:0] hr_data;
  hires_filter u_filter (
    .clock     (clock),
    .rst_n     (rst_n),
    .enable    (hires_q),
    .sample    (adc_s2_q),
    .rate_sel  (rate_q),
    .out_valid (hr_valid),
    .out_data  (hr_data)
  );                                                       // RULE_08

  // store stream: eight-bit samples or wide filtered words
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      store_valid <= 1'b0;
      store_data  <= '0;
    end else if (hires_q) begin
      store_valid <= hr_valid;
      store_data  <= hr_data;
    end else begin
      store_valid <= phase_q || dec_hit;                   // RULE_01
      store_data  <= `RESULT_BITS'(adc_s2_q);
    end
  end

  // calibration sequencer, one step per range then linearity, timing
  logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cal_q           <= CAL_IDLE;
      settle_q        <= '0;
      heater_recenter <= 1'b0;
      cal_step_go     <= 1'b0;
      cal_op          <= OP_GAIN_OFFSET;
      cal_range       <= '0;
      cal_fail_q      <= 1'b0;
      restore_factory <= 1'b0;
    end else begin
      heater_recenter <= 1'b0;
      cal_step_go     <= 1'b0;
      restore_factory <= restore_cmd;                      // RULE_14
      unique case (cal_q)
        CAL_IDLE: begin
          if (cal_cmd) begin
            cal_q      <= CAL_RECENTER;                    // RULE_12
            cal_fail_q <= 1'b0;
          end
        end
        CAL_RECENTER: begin
          heater_recenter <= 1'b1;                         // RULE_13
          settle_q        <= '0;
          cal_q           <= CAL_SETTLE;
        end
        CAL_SETTLE: begin
          // settle time is a floor; the heater must also report stable
          if (settle_q != SETTLE_CYCLES) begin
            settle_q <= settle_q + 1'b1;
          end else if (stable) begin
            cal_q       <= CAL_GAIN;
            cal_op      <= OP_GAIN_OFFSET;
            cal_range   <= '0;
            cal_step_go <= 1'b1;
          end
        end
        CAL_GAIN, CAL_LINEAR, CAL_TIMING: begin
          if (step_done || step_fail) begin
            cal_fail_q <= cal_fail_q | step_fail;
            if (cal_q == CAL_GAIN && cal_range != `RANGE_LAST) begin
              cal_range   <= cal_range + 3'd1;             // RULE_13
              cal_step_go <= 1'b1;
            end else if (cal_q == CAL_GAIN) begin
              cal_q       <= CAL_LINEAR;
              cal_op      <= OP_LINEARITY;
              cal_step_go <= 1'b1;
            end else if (cal_q == CAL_LINEAR) begin
              cal_q       <= CAL_TIMING;
              cal_op      <= OP_TIMING;
              cal_step_go <= 1'b1;
            end else begin
              cal_q <= CAL_IDLE;
            end
          end
        end
      endcase
    end
  end

  // read channel: one word per request, answer one cycle later
  function automatic logic [31:0] read_word(input logic [7:0] a);
    unique case (a)
      `REG_CTRL:        read_word = {30'h0, phase_q, hires_q};
      `REG_DIVISOR:     read_word = divisor_q;
      `REG_PHASE_MULT:  read_word = {28'h0, mult_q};
      `REG_HIRES_RATE:  read_word = {28'h0, rate_q};
      `REG_STATUS:      read_word = {28'h0, cal_fail_q, !cal_idle,
                                     temp_warn_q, overload_q};
      `REG_RESULT_INFO: read_word = {24'h0, store_phase, rate_q};
      default:          read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= read_word(s_axi_araddr);
      s_axi_rresp   <= (s_axi_araddr[7:2] <= `REG_RESULT_INFO >> 2)
                       ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  property p_direct_every_sample;
    @(posedge clock) disable iff (!rst_n)
    (!hires_q && !phase_q && divisor_q == 32'h0)[*2] |=> store_valid;
  endproperty
  a_direct_every_sample: assert property (p_direct_every_sample)  // RULE_03
    else $error("direct mode with n=1 skipped a sample");

  property p_decimate_gap;
    @(posedge clock) disable iff (!rst_n)
    (!hires_q && !phase_q && divisor_q == 32'h1 && store_valid &&
     $stable(divisor_q)) ##0 (!hires_q && !phase_q)[*2] |-> !store_valid;
  endproperty
  a_decimate_gap: assert property (p_decimate_gap)                 // RULE_02
    else $error("divide by two stored adjacent samples");

  property p_mult_range;
    @(posedge clock) disable iff (!rst_n)
    mult_q >= `PHASE_MULT_MIN && mult_q <= `PHASE_MULT_MAX;
  endproperty
  a_mult_range: assert property (p_mult_range)                     // RULE_04
    else $error("phase multiplier out of range");

  property p_phase_slot;
    @(posedge clock) disable iff (!rst_n)
    store_phase < mult_q || $changed(mult_q);
  endproperty
  a_phase_slot: assert property (p_phase_slot)                     // RULE_05
    else $error("phase slot beyond multiplier");

  property p_overload_set;
    @(posedge clock) disable iff (!rst_n)
    hires_q && overrange |=> overload_q ##1 (overload_q || $past(wr_status));
  endproperty
  a_overload_set: assert property (p_overload_set)                 // RULE_09
    else $error("overrange did not set overload");

  property p_flags_sticky;
    @(posedge clock) disable iff (!rst_n)
    temp_warn_q && !wr_status |=> temp_warn_q;
  endproperty
  a_flags_sticky: assert property (p_flags_sticky)                 // RULE_15
    else $error("temperature flag dropped without clear");

  property p_temp_warn;
    @(posedge clock) disable iff (!rst_n)
    ($signed(temp_s2_q) > 8'sd5) || ($signed(temp_s2_q) < -8'sd5)
      |=> temp_warn_q;
  endproperty
  a_temp_warn: assert property (p_temp_warn)                       // RULE_11
    else $error("temperature excursion not flagged");

  property p_cal_start;
    @(posedge clock) disable iff (!rst_n)
    cal_idle && cal_cmd |-> ##2 heater_recenter ##1 cal_q == CAL_SETTLE;
  endproperty
  a_cal_start: assert property (p_cal_start)                       // RULE_12
    else $error("calibration did not recentre heater");

  property p_restore_idle;
    @(posedge clock) disable iff (!rst_n)
    restore_factory |-> $past(cal_idle);
  endproperty
  a_restore_idle: assert property (p_restore_idle)                 // RULE_14
    else $error("restore issued during calibration");

endmodule : digitizer_ctrl
`default_nettype wire

//--- front_model.sv
// converter front end, heater and calibration step responder
`default_nettype none
module front_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       fail_en,
  input  wire logic       heater_recenter,
  input  wire logic       cal_step_go,
  output logic [7:0]      adc_data,
  output logic            heater_stable,
  output logic            cal_step_done,
  output logic            cal_step_fail
);
  timeunit 1ns;
  timeprecision 1ns;
  int settle;
  int step;
  // heater settles slower than the design's own wait, steps answer late
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      adc_data      <= 8'h00;
      settle        <= 0;
      step          <= 0;
      heater_stable <= 1'b1;
      cal_step_done <= 1'b0;
      cal_step_fail <= 1'b0;
    end else begin
      adc_data      <= 8'($urandom);
      cal_step_done <= 1'b0;
      cal_step_fail <= 1'b0;
      if (heater_recenter) begin
        settle        <= 15;
        heater_stable <= 1'b0;
      end else if (settle > 0) begin
        settle        <= settle - 1;
        heater_stable <= (settle == 1);
      end
      if (cal_step_go) step <= 3;
      else if (step > 0) step <= step - 1;
      if (step == 1) begin
        cal_step_done <= !fail_en;
        cal_step_fail <= fail_en;
      end
    end
  end
endmodule : front_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the digitizer mode and rate control
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst_n, fail_en, repeat_start, adc_overrange;
  logic [7:0]  awaddr, araddr, temp_offset_c, adc_data;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, store_phase;
  logic [1:0]  bresp, rresp, cal_op, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, store_valid;
  logic        heater_stable, cal_step_done, cal_step_fail;
  logic        heater_recenter, cal_step_go, restore_factory;
  logic [20:0] store_data, mask;
  logic [2:0]  cal_range;
  int          errors, n_tests, n_store, n_go, n_rec, n_rest, bad, pmax;
  int          m [int];
  digitizer_ctrl #(.SETTLE_CYCLES(8)) dut (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .adc_data(adc_data),
    .adc_overrange(adc_overrange), .temp_offset_c(temp_offset_c),
    .heater_stable(heater_stable), .cal_step_done(cal_step_done),
    .cal_step_fail(cal_step_fail), .repeat_start(repeat_start),
    .store_valid(store_valid), .store_data(store_data),
    .store_phase(store_phase), .heater_recenter(heater_recenter),
    .cal_step_go(cal_step_go), .cal_op(cal_op), .cal_range(cal_range),
    .restore_factory(restore_factory));
  front_model fm (.clock(clock), .rst_n(rst_n), .fail_en(fail_en),
    .heater_recenter(heater_recenter), .cal_step_go(cal_step_go),
    .adc_data(adc_data), .heater_stable(heater_stable),
    .cal_step_done(cal_step_done), .cal_step_fail(cal_step_fail));
  // 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // pulse counters; step order is gain per range, linearity, timing
  always @(posedge clock) begin
    if (store_valid) n_store++;
    if (store_valid && (store_data & mask) != 0) bad++;
    if (store_valid && store_phase > pmax) pmax = store_phase;
    if (heater_recenter) n_rec++;
    if (restore_factory) n_rest++;
    if (cal_step_go) begin
      if (cal_op !== (n_go < 7 ? 2'h0 : 2'(n_go - 6))) bad++;
      if (n_go < 7 && cal_range !== 3'(n_go)) bad++;
      n_go++;
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // write, then fold the same bytes and clamps into the model
  task automatic wr(logic [7:0] a, logic [31:0] v, logic [3:0] s,
                    logic [1:0] er);
    logic [31:0] o;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
    o = m.exists(a) ? m[a] : 0;
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i+:8] = v[8*i+:8];
    if (a == 8'h08) o = o < 2 ? 2 : o > 10 ? 10 : o;
    if (a == 8'h0C) o = o > 9 ? 9 : o;
    if (m.exists(a)) m[a] = o;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rchk(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    rd(a);
    chk($sformatf("reg %h", a), e, d);
    chk("rresp", er, r);
  endtask : rchk
  // let old words drain, then count stored words over a window
  task automatic rate(int cyc, int e, logic [20:0] msk);
    int s0;
    repeat (30) @(negedge clock);
    mask = msk;
    s0 = n_store;
    repeat (cyc) @(negedge clock);
    chk("store count", e, n_store - s0);
    mask = '0;
  endtask : rate
  task automatic pulse_ovr();
    @(posedge clock);
    adc_overrange <= 1'b1;
    @(posedge clock);
    adc_overrange <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : pulse_ovr
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, adc_overrange} = '0;
    {awaddr, araddr, wdata, wstrb, temp_offset_c, repeat_start} = '0;
    {errors, n_tests, n_store, n_go, n_rec, n_rest, bad, pmax} = '0;
    mask = '0;
    fail_en = 1'b1;
    rst_n = 1'b0;
    m[8'h04] = 0;
    m[8'h08] = 2;
    m[8'h0C] = 0;
    void'($urandom(32'hD4D0FC75));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    foreach (m[a]) rchk(8'(a), m[a], 2'h0);
    rchk(8'h10, 32'h0, 2'h0);
    rchk(8'h14, 32'h0, 2'h0);
    wr(8'h18, $urandom, 4'hF, 2'h2);
    rchk(8'h18, 32'h0, 2'h2);
    wr(8'h04, $urandom, 4'hF, 2'h0);
    wr(8'h04, 32'hFFFF_FFFF, 4'h2, 2'h0);
    rchk(8'h04, m[8'h04], 2'h0);
    wr(8'h04, 32'h1, 4'hF, 2'h0);
    rate(20, 10, 21'h1FFF00);
    wr(8'h04, 32'h0, 4'hF, 2'h0);
    rate(20, 20, 21'h1FFF00);
    pulse_ovr();
    rchk(8'h10, 32'h0, 2'h0);
    foreach (m[a]) if (a != 4) wr(8'(a), $urandom % 16, 4'hF, 2'h0);
    foreach (m[a]) rchk(8'(a), m[a], 2'h0);
    wr(8'h08, 32'hA, 4'hF, 2'h0);
    wr(8'h00, 32'h2, 4'hF, 2'h0);
    repeat_start <= 1'b1;
    repeat (12) @(posedge clock);
    repeat_start <= 1'b0;
    rate(20, 20, 21'h1FFF00);
    chk("phase max", 9, pmax);
    wr(8'h0C, 32'h0, 4'hF, 2'h0);
    wr(8'h00, 32'h1, 4'hF, 2'h0);
    rate(80, 10, 21'h0003FF);
    wr(8'h0C, 32'h1, 4'hF, 2'h0);
    rate(200, 10, 21'h00007F);
    pulse_ovr();
    rchk(8'h10, 32'h1, 2'h0);
    repeat (20) @(posedge clock);
    rchk(8'h10, 32'h1, 2'h0);
    wr(8'h10, 32'h1, 4'hF, 2'h0);
    temp_offset_c <= 8'h05;
    repeat (6) @(posedge clock);
    rchk(8'h10, 32'h0, 2'h0);
    temp_offset_c <= 8'hFA;
    repeat (6) @(posedge clock);
    temp_offset_c <= 8'h00;
    repeat (6) @(posedge clock);
    rchk(8'h10, 32'h2, 2'h0);
    wr(8'h10, 32'h2, 4'hF, 2'h0);
    wr(8'h00, 32'h10, 4'hF, 2'h0);
    rchk(8'h10, 32'h4, 2'h0);
    wr(8'h00, 32'h30, 4'hF, 2'h0);
    do rd(8'h10); while (d[2] !== 1'b0);
    chk("cal status", 32'h8, d);
    chk("recentre", 1, n_rec);
    chk("steps", 9, n_go);
    chk("bad words or steps", 0, bad);
    chk("restore busy", 0, n_rest);
    wr(8'h00, 32'h20, 4'hF, 2'h0);
    repeat (4) @(posedge clock);
    chk("restore", 1, n_rest);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
